// >>> rtl/adaptation_step_profile.sv
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/10ps
`include "adapt_profile_defs.svh"

module adaptation_step_profile #(
	parameter int TAP_W = 10
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Avalon-MM slave, byte address
	input wire logic [7:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	// Tap query from the adaptive filter
	input wire logic tap_valid_i,
	input wire logic [TAP_W-1:0] tap_index_i,
	// Profile answers, one cycle after the query
	output logic gain_valid_o,
	output adapt_profile_pkg::gain_region_e region_a_o,
	output adapt_profile_pkg::gain_exp_t gain_exp_a_o,
	output adapt_profile_pkg::gain_region_e region_b_o,
	output adapt_profile_pkg::gain_exp_t gain_exp_b_o,
	// Control register 3 contents for the rest of each canceller
	output logic [7:0] canceller_control_three_a_o,
	output logic [7:0] canceller_control_three_b_o
);
	import adapt_profile_pkg::*;

	// Tap index must reach 1023 for the extended filter
	initial begin
		if (TAP_W < 10 || TAP_W > 17) begin
			$error("TAP_W must lie between 10 and 17");
		end
	end

	// Profile registers, one copy per canceller
	logic [7:0] flat_delay_a, next_flat_delay_a;
	logic [2:0] decay_step_size_a, next_decay_step_size_a;
	logic [7:0] decay_step_count_a, next_decay_step_count_a;
	logic [7:0] canceller_control_three_a, next_canceller_control_three_a;
	logic [7:0] flat_delay_b, next_flat_delay_b;
	logic [2:0] decay_step_size_b, next_decay_step_size_b;
	logic [7:0] decay_step_count_b, next_decay_step_count_b;
	logic [7:0] canceller_control_three_b, next_canceller_control_three_b;
	// Extended filter length per canceller
	logic [1:0] profile_mode, next_profile_mode;

	// Bus handshake state
	logic bus_ack, next_bus_ack;
	logic [31:0] read_word, next_read_word;

	// Answer registers
	logic gain_valid, next_gain_valid;
	gain_region_e region_a, next_region_a, region_b, next_region_b;
	gain_exp_t gain_exp_a, next_gain_exp_a, gain_exp_b, next_gain_exp_b;

	// Decoder outputs
	logic [5:0] reg_index;
	logic lane_ok;
	logic do_write;
	gain_region_e look_region_a, look_region_b;
	gain_exp_t look_exp_a, look_exp_b;

	// Lookup for canceller a
	profile_lookup #(
		.TAP_W(TAP_W)
	) lookup_a (
		.tap_i(tap_index_i),
		.flat_delay_count_i(flat_delay_a),
		.decay_span_code_i(decay_step_size_a),
		.decay_step_count_i(decay_step_count_a),
		.extended_i(profile_mode[`MODE_EXT_A]),
		.region_o(look_region_a),
		.gain_exp_o(look_exp_a)
	);

	// Lookup for canceller b, fed from its own copy
	profile_lookup #(
		.TAP_W(TAP_W)
	) lookup_b (
		.tap_i(tap_index_i),
		.flat_delay_count_i(flat_delay_b),
		.decay_span_code_i(decay_step_size_b),
		.decay_step_count_i(decay_step_count_b),
		.extended_i(profile_mode[`MODE_EXT_B]),
		.region_o(look_region_b),
		.gain_exp_o(look_exp_b)
	);

	// Address split; sub-word addresses answer but hit nothing
	assign reg_index = address_i[7:`ADDR_LANE_BITS];
	assign lane_ok = (address_i[`ADDR_LANE_BITS-1:0] == 2'h0);
	assign do_write = write_i && bus_ack && lane_ok;

	// One wait cycle on every access, then the answer
	assign waitrequest_o = (read_i || write_i) && !bus_ack;

	// Bus handshake and read mux
	always_comb begin
		next_bus_ack = (read_i || write_i) && !bus_ack;
		next_read_word = read_word;
		if (read_i && !bus_ack) begin
			next_read_word = 32'h00000000;
			if (lane_ok) begin
				unique case (reg_index)
					`IDX_FLAT_DELAY_A: next_read_word = 32'(flat_delay_a);
					// Upper span code bits read back as zero
					`IDX_SPAN_CODE_A: next_read_word = 32'(decay_step_size_a);
					`IDX_STEP_COUNT_A: next_read_word = 32'(decay_step_count_a);
					`IDX_CTRL3_A: next_read_word = 32'(canceller_control_three_a);
					`IDX_FLAT_DELAY_B: next_read_word = 32'(flat_delay_b);
					`IDX_SPAN_CODE_B: next_read_word = 32'(decay_step_size_b);
					`IDX_STEP_COUNT_B: next_read_word = 32'(decay_step_count_b);
					`IDX_CTRL3_B: next_read_word = 32'(canceller_control_three_b);
					`IDX_MODE: next_read_word = 32'(profile_mode);
					`IDX_STATUS: begin
						// Last answer given to the filter
						next_read_word[`STAT_REGION_A_LSB +: 2] = region_a;
						next_read_word[`STAT_REGION_B_LSB +: 2] = region_b;
						next_read_word[`STAT_VALID_BIT] = gain_valid;
					end
					// Unmapped words read as zero
					default: next_read_word = 32'h00000000;
				endcase
			end
		end
	end

	// Register writes, taken at the edge where waitrequest is low
	always_comb begin
		next_flat_delay_a = flat_delay_a;
		next_decay_step_size_a = decay_step_size_a;
		next_decay_step_count_a = decay_step_count_a;
		next_canceller_control_three_a = canceller_control_three_a;
		next_flat_delay_b = flat_delay_b;
		next_decay_step_size_b = decay_step_size_b;
		next_decay_step_count_b = decay_step_count_b;
		next_canceller_control_three_b = canceller_control_three_b;
		next_profile_mode = profile_mode;
		if (do_write) begin
			unique case (reg_index)
				// Range of flat delay is software's duty; not clamped here
				`IDX_FLAT_DELAY_A: next_flat_delay_a = writedata_i[7:0];
				// Only the low three bits are kept
				`IDX_SPAN_CODE_A: next_decay_step_size_a = writedata_i[2:0];
				`IDX_STEP_COUNT_A: next_decay_step_count_a = writedata_i[7:0];
				`IDX_CTRL3_A: next_canceller_control_three_a = writedata_i[7:0];
				`IDX_FLAT_DELAY_B: next_flat_delay_b = writedata_i[7:0];
				`IDX_SPAN_CODE_B: next_decay_step_size_b = writedata_i[2:0];
				`IDX_STEP_COUNT_B: next_decay_step_count_b = writedata_i[7:0];
				`IDX_CTRL3_B: next_canceller_control_three_b = writedata_i[7:0];
				`IDX_MODE: next_profile_mode = writedata_i[1:0];
				// Writes elsewhere are accepted and dropped
				default: next_profile_mode = profile_mode;
			endcase
		end
	end

	// Answer one cycle after each tap query
	always_comb begin
		next_gain_valid = tap_valid_i;
		next_region_a = region_a;
		next_gain_exp_a = gain_exp_a;
		next_region_b = region_b;
		next_gain_exp_b = gain_exp_b;
		if (tap_valid_i) begin
			next_region_a = look_region_a;
			next_gain_exp_a = look_exp_a;
			next_region_b = look_region_b;
			next_gain_exp_b = look_exp_b;
		end
	end

	// All state registers; defaults load at reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			flat_delay_a <= `RST_FLAT_DELAY;
			decay_step_size_a <= `RST_SPAN_CODE;
			decay_step_count_a <= `RST_STEP_COUNT;
			canceller_control_three_a <= `RST_CTRL3;
			flat_delay_b <= `RST_FLAT_DELAY;
			decay_step_size_b <= `RST_SPAN_CODE;
			decay_step_count_b <= `RST_STEP_COUNT;
			canceller_control_three_b <= `RST_CTRL3;
			profile_mode <= `RST_MODE;
			bus_ack <= 1'b0;
			read_word <= 32'h00000000;
			gain_valid <= 1'b0;
			region_a <= REGION_FLAT;
			gain_exp_a <= 9'h000;
			region_b <= REGION_FLAT;
			gain_exp_b <= 9'h000;
		end else begin
			flat_delay_a <= next_flat_delay_a;
			decay_step_size_a <= next_decay_step_size_a;
			decay_step_count_a <= next_decay_step_count_a;
			canceller_control_three_a <= next_canceller_control_three_a;
			flat_delay_b <= next_flat_delay_b;
			decay_step_size_b <= next_decay_step_size_b;
			decay_step_count_b <= next_decay_step_count_b;
			canceller_control_three_b <= next_canceller_control_three_b;
			profile_mode <= next_profile_mode;
			bus_ack <= next_bus_ack;
			read_word <= next_read_word;
			gain_valid <= next_gain_valid;
			region_a <= next_region_a;
			gain_exp_a <= next_gain_exp_a;
			region_b <= next_region_b;
			gain_exp_b <= next_gain_exp_b;
		end
	end

	// Outputs straight from flip-flops
	assign readdata_o = read_word;
	assign gain_valid_o = gain_valid;
	assign region_a_o = region_a;
	assign gain_exp_a_o = gain_exp_a;
	assign region_b_o = region_b;
	assign gain_exp_b_o = gain_exp_b;
	assign canceller_control_three_a_o = canceller_control_three_a;
	assign canceller_control_three_b_o = canceller_control_three_b;

endmodule : adaptation_step_profile

// >>> shared/adapt_profile_defs.svh
`ifndef ADAPT_PROFILE_DEFS_SVH
`define ADAPT_PROFILE_DEFS_SVH

// Register indices; byte address on the bus is four times the index
`define IDX_FLAT_DELAY_A 6'h04
`define IDX_SPAN_CODE_A 6'h06
`define IDX_STEP_COUNT_A 6'h07
`define IDX_CTRL3_A 6'h08
`define IDX_FLAT_DELAY_B 6'h24
`define IDX_SPAN_CODE_B 6'h26
`define IDX_STEP_COUNT_B 6'h27
`define IDX_CTRL3_B 6'h28
`define IDX_MODE 6'h30
`define IDX_STATUS 6'h31

// Byte lane bits below the word index
`define ADDR_LANE_BITS 2

// Reset values
`define RST_FLAT_DELAY 8'h00
`define RST_SPAN_CODE 3'h4
`define RST_STEP_COUNT 8'h00
`define RST_CTRL3 8'hfb
`define RST_MODE 2'h0

// Field positions in the mode register
`define MODE_EXT_A 0
`define MODE_EXT_B 1

// Field positions in the status register
`define STAT_REGION_A_LSB 0
`define STAT_REGION_B_LSB 2
`define STAT_VALID_BIT 4

// Profile arithmetic
`define FLAT_TAP_SHIFT 3
`define SPAN_BASE_SHIFT 4'h2
`define FILTER_LEN_NORMAL 18'h00200
`define FILTER_LEN_EXT 18'h00400
`define FLAT_GAIN_EXP 9'h010

// One tap equals one sample period
`define TAP_PERIOD_US 125

`endif

// >>> shared/adapt_profile_pkg.sv
package adapt_profile_pkg;

	// Which part of the profile a tap falls in
	typedef enum logic [1:0] {
		REGION_FLAT,
		REGION_NOMINAL,
		REGION_DECAY
	} gain_region_e;

	// Count of halvings below the nominal gain
	typedef logic [8:0] gain_exp_t;

endpackage : adapt_profile_pkg

// >>> rtl/profile_lookup.sv
`timescale 1ns/10ps
`include "adapt_profile_defs.svh"

module profile_lookup #(
	parameter int TAP_W = 10
) (
	// Tap under evaluation
	input wire logic [TAP_W-1:0] tap_i,
	// Profile settings of one canceller
	input wire logic [7:0] flat_delay_count_i,
	input wire logic [2:0] decay_span_code_i,
	input wire logic [7:0] decay_step_count_i,
	input wire logic extended_i,
	// Profile answer
	output adapt_profile_pkg::gain_region_e region_o,
	output adapt_profile_pkg::gain_exp_t gain_exp_o
);
	import adapt_profile_pkg::*;

	// Working values, wide enough for 255 steps of 512 taps
	logic [17:0] tap_wide;
	logic [17:0] flat_end;
	logic [3:0] span_shift;
	logic [17:0] decay_len;
	logic [17:0] filter_len;
	logic [17:0] decay_start;
	logic [17:0] decay_offset;
	logic [17:0] steps_in;

	// Pure lookup; the caller registers the result
	always_comb begin
		tap_wide = 18'(tap_i);
		flat_end = 18'(flat_delay_count_i) << `FLAT_TAP_SHIFT;
		span_shift = 4'(decay_span_code_i) + `SPAN_BASE_SHIFT;
		decay_len = 18'(decay_step_count_i) << span_shift;
		// One tap per sample, so length is 512 or 1024 taps
		filter_len = extended_i ? `FILTER_LEN_EXT : `FILTER_LEN_NORMAL;
		// Too many steps would start before tap zero; clamp there
		decay_start = (decay_len >= filter_len) ? 18'h00000 : filter_len - decay_len;
		decay_offset = tap_wide - decay_start;
		steps_in = (decay_offset >> span_shift) + 18'h00001;
		region_o = REGION_NOMINAL;
		gain_exp_o = 9'h000;
		if (tap_wide < flat_end) begin
			// Flat region wins over an overlapping decay region
			region_o = REGION_FLAT;
			gain_exp_o = `FLAT_GAIN_EXP;
		end else if (tap_wide >= decay_start) begin
			// Halve once per span from the decay start
			region_o = REGION_DECAY;
			gain_exp_o = steps_in[8:0];
		end else begin
			// Between the two regions the full gain applies
			region_o = REGION_NOMINAL;
			gain_exp_o = 9'h000;
		end
	end

endmodule : profile_lookup

// >>> testbench/adaptation_step_profile_assertions.sv
`timescale 1ns/10ps
module adaptation_step_profile_chk import adapt_profile_pkg::*; #(
	parameter int TAP_W = 10
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Bus handshake
	input wire logic read_i,
	input wire logic write_i,
	input wire logic waitrequest_o,
	// Tap query and answers
	input wire logic tap_valid_i,
	input wire logic gain_valid_o,
	input wire adapt_profile_pkg::gain_region_e region_a_o,
	input wire adapt_profile_pkg::gain_exp_t gain_exp_a_o,
	input wire adapt_profile_pkg::gain_region_e region_b_o,
	input wire adapt_profile_pkg::gain_exp_t gain_exp_b_o
);
	// One clock domain, so one default clocking and disable
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	AST_WAIT_RISE: assert property ($rose(read_i | write_i) |-> waitrequest_o)
		else $error("No wait state on a new request");
	AST_WAIT_ONE: assert property (waitrequest_o |=> !waitrequest_o)
		else $error("Wait state longer than one cycle");
	AST_IDLE_NO_WAIT: assert property (!(read_i | write_i) |-> !waitrequest_o)
		else $error("Wait asserted without a request");
	AST_ANSWER: assert property (tap_valid_i |=> gain_valid_o)
		else $error("Query not answered next cycle");
	AST_NO_ANSWER: assert property (!tap_valid_i |=> !gain_valid_o)
		else $error("Answer without a query");
	AST_HOLD: assert property (!tap_valid_i |=> $stable(gain_exp_a_o) && $stable(region_b_o))
		else $error("Profile answer moved without a query");
	AST_FLAT_A: assert property (gain_valid_o && region_a_o == REGION_FLAT |-> gain_exp_a_o == 9'h010)
		else $error("Flat tap of a not at minimum gain");
	AST_FLAT_B: assert property (gain_valid_o && region_b_o == REGION_FLAT |-> gain_exp_b_o == 9'h010)
		else $error("Flat tap of b not at minimum gain");
	AST_NOMINAL: assert property (gain_valid_o && region_a_o == REGION_NOMINAL |-> gain_exp_a_o == 9'h000)
		else $error("Nominal tap not at full gain");
	AST_DECAY: assert property (gain_valid_o && region_b_o == REGION_DECAY |-> gain_exp_b_o != 9'h000)
		else $error("Decay tap not halved");
endmodule : adaptation_step_profile_chk

bind adaptation_step_profile adaptation_step_profile_chk #(.TAP_W(TAP_W)) u_chk (.*);

// >>> testbench/adaptation_step_profile_tb_top.sv
`timescale 1ns/10ps
module adaptation_step_profile_tb_top;
	import adapt_profile_pkg::*;
	// Design ports
	logic clk_i, reset_n_i, read_i, write_i, waitrequest_o, tap_valid_i, gain_valid_o;
	logic [7:0] address_i, ctrl_a, ctrl_b;
	logic [31:0] writedata_i, readdata_o;
	logic [9:0] tap_index_i;
	gain_region_e region_a_o, region_b_o;
	gain_exp_t gain_exp_a_o, gain_exp_b_o;
	int err_count = 0;
	int checks_done = 0;
	// Profile registers of a then b, and their reset values
	logic [7:0] ad [8] = '{8'h10, 8'h18, 8'h1c, 8'h20, 8'h90, 8'h98, 8'h9c, 8'ha0};
	logic [31:0] rv [8] = '{0, 4, 0, 'hfb, 0, 4, 0, 'hfb};
	adaptation_step_profile u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.address_i(address_i), .read_i(read_i), .write_i(write_i),
		.writedata_i(writedata_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
		.tap_valid_i(tap_valid_i), .tap_index_i(tap_index_i), .gain_valid_o(gain_valid_o),
		.region_a_o(region_a_o), .gain_exp_a_o(gain_exp_a_o), .region_b_o(region_b_o),
		.gain_exp_b_o(gain_exp_b_o), .canceller_control_three_a_o(ctrl_a),
		.canceller_control_three_b_o(ctrl_b));
	// 25 MHz clock
	always #20 clk_i = ~clk_i;
	// Compare and count
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			$display("ERROR %0t got %h exp %h", $time, g, e);
			err_count++;
		end
	endtask : chk
	// One Avalon access; the answer edge is found, never assumed
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		address_i <= a;
		read_i <= !w;
		write_i <= w;
		writedata_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (waitrequest_o !== 1'b0 && n < 16);
		q = readdata_o;
		if (waitrequest_o !== 1'b0) err_count++;
		read_i <= 1'b0;
		write_i <= 1'b0;
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk(q, e);
	endtask : rd
	// One tap query, answer judged in the cycle after
	task tq(input int t, gain_region_e ra, gain_exp_t ea, gain_region_e rb, gain_exp_t eb);
		@(posedge clk_i);
		tap_valid_i <= 1'b1;
		tap_index_i <= t[9:0];
		@(posedge clk_i);
		tap_valid_i <= 1'b0;
		#1;
		chk({31'h0, gain_valid_o}, 32'h1);
		chk({21'h0, region_a_o, gain_exp_a_o}, {21'h0, ra, ea});
		chk({21'h0, region_b_o, gain_exp_b_o}, {21'h0, rb, eb});
	endtask : tq
	// Defaults of both copies, and unmapped places
	task test_reset;
		for (int i = 0; i < 8; i++) rd(ad[i], rv[i]);
		rd(8'h40, 32'h0);
		rd(8'h11, 32'h0);
		chk({24'h0, ctrl_a}, 32'hfb);
		chk({24'h0, ctrl_b}, 32'hfb);
		$display("test_reset done");
	endtask : test_reset
	// Distinct values show each copy stands alone
	task test_regs;
		for (int i = 0; i < 8; i++) wr(ad[i], 32'h38 + i);
		for (int i = 0; i < 8; i++) rd(ad[i], (i % 4 == 1) ? (32'h38 + i) & 7 : 32'h38 + i);
		chk({24'h0, ctrl_a, ctrl_b}, 32'h3b3f);
		wr(8'h44, 32'h55);
		rd(8'h44, 32'h0);
		$display("test_regs done");
	endtask : test_regs
	// Region edges for both cancellers, normal and extended
	task test_profile;
		wr(8'h10, 0);
		wr(8'h18, 4);
		wr(8'h1c, 4);
		wr(8'h90, 5);
		wr(8'h98, 0);
		wr(8'h9c, 2);
		wr(8'hc0, 0);
		tq(39, REGION_NOMINAL, 0, REGION_FLAT, 16);
		tq(40, REGION_NOMINAL, 0, REGION_NOMINAL, 0);
		tq(255, REGION_NOMINAL, 0, REGION_NOMINAL, 0);
		tq(256, REGION_DECAY, 1, REGION_NOMINAL, 0);
		tq(320, REGION_DECAY, 2, REGION_NOMINAL, 0);
		tq(507, REGION_DECAY, 4, REGION_DECAY, 1);
		tq(508, REGION_DECAY, 4, REGION_DECAY, 2);
		wr(8'hc0, 3);
		tq(767, REGION_NOMINAL, 0, REGION_NOMINAL, 0);
		tq(768, REGION_DECAY, 1, REGION_NOMINAL, 0);
		tq(1016, REGION_DECAY, 4, REGION_DECAY, 1);
		wr(8'h10, 128);
		tq(1023, REGION_FLAT, 16, REGION_DECAY, 2);
		$display("test_profile done");
	endtask : test_profile
	// Verdict, single exit
	task finish_test;
		$display("Checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : finish_test
	// Watchdog well beyond the expected run of about 140 cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		finish_test();
	end
	// Main sequence
	initial begin
		clk_i = 1'b0;
		reset_n_i = 1'b0;
		{read_i, write_i, tap_valid_i} = 3'h0;
		address_i = 8'h0;
		writedata_i = 32'h0;
		tap_index_i = 10'h0;
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		test_reset();
		test_regs();
		test_profile();
		finish_test();
	end
endmodule : adaptation_step_profile_tb_top
